// ### verilog/rcf_failover_buffer.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: choice high takes input one, low two
// R2: select 00 bypasses loop and oscillator
// R3: select sets ratio half, two, six
// R4: select 10 reference 16 to 50 MHz
// R5: select 11 reference 50 to 166.7 MHz
// R6: accept references 4.17 to 166.7 MHz
// R7: validity high while reference valid, else low
// R8: on stop freeze tuning, keep clocks, flag
// R9: tune only inside capture range, else invalid
// R10: returning reference clears the failure flag
// R11: oscillator realigns to restored reference automatically
// R12: flag within 2n periods, clears after 12n
// R13: loop always runs from tuned oscillator
// R14: one output wired back as feedback
// R15: four aligned outputs in two banks
// R16: bypass outputs follow reference directly
module rcf_failover_buffer #(
    parameter int W = 32,
    parameter int TW = 24,
    parameter int PW = 16,
    parameter logic [31:0] NOMINAL_WORD = 32'h20000000,
    parameter int TRIM_STEP = 16
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic refIn1,
    input wire logic refIn2,
    input wire logic referenceChoice,
    input wire logic [1:0] freqSel,
    input wire logic loopReturnIn,
    output logic crystalOut,
    output logic [1:0] bankAClockOut,
    output logic [1:0] bankBClockOut,
    output logic refValid,
    output logic irq,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    localparam longint unsigned LIMIT_L = (64'(NOMINAL_WORD) * 64'(rcf_pkg::CAPTURE_PPM)) / 64'd1000000;
    localparam logic signed [TW:0] TRIM_MAX = (TW+1)'(LIMIT_L);
    localparam logic signed [TW:0] STEP = (TW+1)'(TRIM_STEP);

    // refuse widths the arithmetic cannot serve
    if (W != 32 || TW < 8 || TW > W - 2 || PW < 8 || TRIM_STEP < 1
        || LIMIT_L + 64'(TRIM_STEP) >= (64'd1 << (TW - 1))) begin : g_bad_param
        $error("rcf_failover_buffer: unsupported parameter set");
    end

    rcf_mon_if #(.PW(PW)) mon ();
    rcf_pkg::rcf_fsel_t fsel;
    rcf_pkg::rcf_state_t state;
    logic bypass;
    logic hold;
    logic tuneEnable;
    logic refPend;
    logic fbPend;
    logic upReq;
    logic dnReq;
    logic capSat;
    logic spanOk;
    logic bad;
    logic signed [TW-1:0] trim;
    logic signed [TW:0] upSum;
    logic signed [TW:0] dnSum;
    logic [W-1:0] xtalWord;
    logic [W-1:0] pllWord;
    logic pllClk;
    logic xtalClk;
    logic [4:0] nHalf;
    logic [PW-1:0] spanMin;
    logic [PW-1:0] spanMax;
    logic [6:0] edgeCnt;
    logic [2:0] padCnt;
    logic [rcf_pkg::EVT_W-1:0] evt;
    logic [rcf_pkg::EVT_W-1:0] status;
    logic [rcf_pkg::EVT_W-1:0] mask;
    logic [rcf_pkg::EVT_W-1:0] next_status;
    logic [rcf_pkg::EVT_W-1:0] readClear;
    logic capSatD;
    logic apbSetup;
    logic apbWrite;

    assign fsel = rcf_pkg::rcf_fsel_t'(freqSel);
    assign bypass = (fsel == rcf_pkg::FS_BYPASS); // R2

    rcf_ref_monitor #(.PW(PW)) u_mon (
        .core_clk(core_clk),
        .rstn(rstn),
        .refIn1(refIn1),
        .refIn2(refIn2),
        .referenceChoice(referenceChoice),
        .loopReturnIn(loopReturnIn),
        .mon(mon.mon)
    );

    // ratio in halves and allowed reference period span per select setting
    always_comb begin
        nHalf = rcf_pkg::RH_HALF;
        spanMin = PW'(rcf_pkg::CORE_10K / rcf_pkg::REF_MAX_10K_SIX);
        spanMax = PW'(rcf_pkg::CORE_10K / rcf_pkg::REF_MIN_10K_HALF); // R6
        unique case (fsel)
            rcf_pkg::FS_BYPASS: begin
            end
            rcf_pkg::FS_HALF: begin
                nHalf = rcf_pkg::RH_HALF; // R3
                spanMin = PW'(rcf_pkg::CORE_10K / rcf_pkg::REF_MAX_10K_HALF);
            end
            rcf_pkg::FS_TWO: begin
                nHalf = rcf_pkg::RH_TWO; // R3
                spanMin = PW'(rcf_pkg::CORE_10K / rcf_pkg::REF_MAX_10K_TWO); // R4
                spanMax = PW'(rcf_pkg::CORE_10K / rcf_pkg::REF_MIN_10K_TWO); // R4
            end
            rcf_pkg::FS_SIX: begin
                nHalf = rcf_pkg::RH_SIX; // R3
                spanMax = PW'(rcf_pkg::CORE_10K / rcf_pkg::REF_MIN_10K_SIX); // R5
            end
        endcase
    end

    // stop limit is 2n periods, i.e. period times n counted in halves
    assign mon.stopLimit = mon.period * nHalf; // R12
    // one cycle of slack for the sampling of the measured period
    assign spanOk = (mon.period + PW'(1) >= spanMin) && (mon.period <= spanMax + PW'(1)); // R6
    assign bad = mon.stopped | ~spanOk | capSat; // R9
    assign tuneEnable = ~bypass & ~mon.stopped & spanOk & ~hold; // R8

    // bang-bang phase detector: who arrived first since the last pair
    assign upReq = tuneEnable & mon.fbEdge & ~mon.refEdge & refPend;
    assign dnReq = tuneEnable & mon.refEdge & ~mon.fbEdge & fbPend;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            refPend <= 1'b0;
            fbPend <= 1'b0;
        end else if (!tuneEnable || (mon.refEdge && mon.fbEdge)) begin
            refPend <= 1'b0;
            fbPend <= 1'b0;
        end else if (mon.refEdge) begin
            refPend <= ~fbPend;
            fbPend <= 1'b0;
        end else if (mon.fbEdge) begin
            fbPend <= ~refPend;
            refPend <= 1'b0;
        end
    end

    // trim word steps toward the reference and saturates at the capture edge
    assign upSum = {trim[TW-1], trim} + STEP;
    assign dnSum = {trim[TW-1], trim} - STEP;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            trim <= '0;
            capSat <= 1'b0;
        end else if (upReq) begin
            if (upSum > TRIM_MAX) begin
                trim <= TW'(TRIM_MAX); // R9
                capSat <= 1'b1; // R9
            end else begin
                trim <= TW'(upSum); // R11
                capSat <= 1'b0;
            end
        end else if (dnReq) begin
            if (dnSum < -TRIM_MAX) begin
                trim <= TW'(-TRIM_MAX); // R9
                capSat <= 1'b1; // R9
            end else begin
                trim <= TW'(dnSum); // R11
                capSat <= 1'b0;
            end
        end
    end

    // oscillator word, and the loop word derived only from it
    assign xtalWord = NOMINAL_WORD + {{(W-TW){trim[TW-1]}}, trim};
    always_comb begin
        pllWord = xtalWord;
        unique case (fsel)
            rcf_pkg::FS_BYPASS: pllWord = xtalWord;
            rcf_pkg::FS_HALF: pllWord = {1'b0, xtalWord[W-1:1]}; // R13
            rcf_pkg::FS_TWO: pllWord = {xtalWord[W-2:0], 1'b0}; // R13
            rcf_pkg::FS_SIX: pllWord = {xtalWord[W-3:0], 2'b00} + {xtalWord[W-2:0], 1'b0}; // R13
        endcase
    end

    rcf_nco #(.W(W)) u_xtal (
        .core_clk(core_clk),
        .rstn(rstn),
        .word(xtalWord),
        .clkOut(xtalClk)
    );

    rcf_nco #(.W(W)) u_pll (
        .core_clk(core_clk),
        .rstn(rstn),
        .word(pllWord),
        .clkOut(pllClk)
    );

    // output banks: loop clock normally, reference itself in bypass
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            bankAClockOut <= 2'h0;
            bankBClockOut <= 2'h0;
            crystalOut <= 1'b0;
        end else begin
            bankAClockOut <= bypass ? {2{mon.refLevel}} : {2{pllClk}}; // R15
            bankBClockOut <= bypass ? {2{mon.refLevel}} : {2{pllClk}}; // R16
            crystalOut <= xtalClk;
        end
    end

    // validity tracker
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state <= rcf_pkg::ST_FAILED;
            refValid <= 1'b0;
            edgeCnt <= 7'h00;
            padCnt <= 3'h0;
        end else begin
            unique case (state)
                rcf_pkg::ST_VALID: begin
                    if (bad) begin
                        state <= rcf_pkg::ST_FAILED;
                        refValid <= 1'b0; // R8
                    end
                end
                rcf_pkg::ST_FAILED: begin
                    if (mon.refEdge && !bad) begin
                        state <= rcf_pkg::ST_RECOVER; // R10
                        edgeCnt <= 7'h00;
                    end
                end
                rcf_pkg::ST_RECOVER: begin
                    if (bad) begin
                        state <= rcf_pkg::ST_FAILED;
                    end else if (mon.refEdge) begin
                        edgeCnt <= edgeCnt + 7'h01;
                        // 12n periods equal six periods per half of n
                        if (edgeCnt + 7'h01 >= 7'(rcf_pkg::RESTORE_PERIODS / 2) * 7'(nHalf)) begin
                            state <= rcf_pkg::ST_PAD; // R12
                            padCnt <= 3'h0;
                        end
                    end
                end
                rcf_pkg::ST_PAD: begin
                    if (bad) begin
                        state <= rcf_pkg::ST_FAILED;
                    end else if (padCnt == 3'(rcf_pkg::FLAG_PAD_CYC - 1)) begin
                        state <= rcf_pkg::ST_VALID; // R10
                        refValid <= 1'b1; // R7
                    end else begin
                        padCnt <= padCnt + 3'h1;
                    end
                end
            endcase
        end
    end

    // events: failure, restore, capture limit reached
    assign evt[rcf_pkg::EVT_FAIL] = (state == rcf_pkg::ST_VALID) & bad;
    assign evt[rcf_pkg::EVT_RESTORE] = (state == rcf_pkg::ST_PAD) & ~bad
        & (padCnt == 3'(rcf_pkg::FLAG_PAD_CYC - 1));
    assign evt[rcf_pkg::EVT_SAT] = capSat & ~capSatD;

    // apb decode
    assign apbSetup = psel & ~penable;
    assign apbWrite = psel & penable & pready & pwrite;
    assign readClear = (psel && penable && pready && !pwrite && paddr == rcf_pkg::ADDR_STATUS)
        ? prdata[rcf_pkg::EVT_W-1:0] : '0;
    // only bits that were returned are cleared; a new event always wins
    assign next_status = (status & ~readClear) | evt;

    // sticky status, irq level
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            status <= '0;
            capSatD <= 1'b0;
            irq <= 1'b0;
        end else begin
            status <= next_status;
            capSatD <= capSat;
            irq <= |(next_status & mask);
        end
    end

    // writable registers
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mask <= rcf_pkg::MASK_RESET;
            hold <= rcf_pkg::CTRL_HOLD_RESET;
        end else if (apbWrite && paddr == rcf_pkg::ADDR_MASK) begin
            mask <= pwdata[rcf_pkg::EVT_W-1:0];
        end else if (apbWrite && paddr == rcf_pkg::ADDR_CTRL) begin
            hold <= pwdata[rcf_pkg::CTRL_HOLD_BIT];
        end
    end

    // answer one cycle after setup: read data, ready and error from flops
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= apbSetup;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (apbSetup) begin
                unique case (paddr)
                    rcf_pkg::ADDR_STATUS: prdata[rcf_pkg::EVT_W-1:0] <= status;
                    rcf_pkg::ADDR_MASK: prdata[rcf_pkg::EVT_W-1:0] <= mask;
                    rcf_pkg::ADDR_CTRL: prdata[rcf_pkg::CTRL_HOLD_BIT] <= hold;
                    rcf_pkg::ADDR_STATE: begin
                        prdata[rcf_pkg::ST_VALID_BIT] <= refValid;
                        prdata[rcf_pkg::ST_BYPASS_BIT] <= bypass;
                        prdata[rcf_pkg::ST_FROZEN_BIT] <= ~tuneEnable;
                        prdata[rcf_pkg::ST_SAT_BIT] <= capSat;
                        prdata[rcf_pkg::ST_FSEL_LSB +: 2] <= freqSel;
                        prdata[rcf_pkg::ST_REFCH_BIT] <= referenceChoice;
                        prdata[rcf_pkg::ST_TRIM_LSB +: TW] <= trim;
                    end
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence s_valid_hit_bad;
        state == rcf_pkg::ST_VALID && bad;
    endsequence
    sequence s_restore_done;
        state == rcf_pkg::ST_PAD && !bad && padCnt == 3'(rcf_pkg::FLAG_PAD_CYC - 1);
    endsequence

    a_fail_flag_fast: assert property (s_valid_hit_bad |=> !refValid && state == rcf_pkg::ST_FAILED) // R12
        else $error("failure not flagged one cycle after detection");
    a_restore_flag: assert property (s_restore_done |=> refValid ##0 status[rcf_pkg::EVT_RESTORE]) // R10
        else $error("restore did not raise validity and event");
    a_valid_only_st: assert property (refValid == (state == rcf_pkg::ST_VALID)) // R7
        else $error("validity output disagrees with tracker state");
    a_restore_pad: assert property ($rose(refValid) |-> $past(state, 1) == rcf_pkg::ST_PAD // R12
        && $past(state, 5) == rcf_pkg::ST_PAD)
        else $error("validity rose without the full pad");
    a_trim_frozen: assert property (!tuneEnable |=> $stable(trim)) // R8
        else $error("tuning moved while frozen");
    a_trim_bound: assert property (capSat |-> trim == TW'(TRIM_MAX) || trim == TW'(-TRIM_MAX)) // R9
        else $error("saturation flagged away from the capture limit");
    a_ratio_six: assert property (fsel == rcf_pkg::FS_SIX |-> pllWord == W'(xtalWord * 6)) // R3
        else $error("loop word is not six times the oscillator word");
    a_bypass_out: assert property (bypass && $past(bypass) |-> bankAClockOut == {2{$past(mon.refLevel)}} // R16
        && bankBClockOut == bankAClockOut)
        else $error("bypass outputs do not follow the reference");
    a_irq_mask: assert property (##1 irq == |($past(next_status) & $past(mask)))
        else $error("interrupt level does not match masked status");
    a_apb_answer: assert property (apbSetup |=> pready ##1 !pready)
        else $error("apb answer not one cycle after setup");
endmodule
`default_nettype wire

// ### verilog/rcf_pkg.sv
`default_nettype none
// shared constants of the reference failover clock buffer
package rcf_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_MASK = 8'h04;
    localparam logic [7:0] ADDR_STATE = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h0c;
    // event bits, same layout in status and mask
    localparam int EVT_FAIL = 0;
    localparam int EVT_RESTORE = 1;
    localparam int EVT_SAT = 2;
    localparam int EVT_W = 3;
    localparam logic [2:0] MASK_RESET = 3'h0;
    // state register fields
    localparam int ST_VALID_BIT = 0;
    localparam int ST_BYPASS_BIT = 1;
    localparam int ST_FROZEN_BIT = 2;
    localparam int ST_SAT_BIT = 3;
    localparam int ST_FSEL_LSB = 4;
    localparam int ST_REFCH_BIT = 6;
    localparam int ST_TRIM_LSB = 8;
    // control register fields
    localparam int CTRL_HOLD_BIT = 0;
    localparam logic CTRL_HOLD_RESET = 1'b0;
    // frequency select codes
    typedef enum logic [1:0] {
        FS_BYPASS = 2'b00,
        FS_HALF = 2'b01,
        FS_TWO = 2'b10,
        FS_SIX = 2'b11
    } rcf_fsel_t;
    // reference-to-crystal ratio counted in halves
    localparam logic [4:0] RH_HALF = 5'h01;
    localparam logic [4:0] RH_TWO = 5'h04;
    localparam logic [4:0] RH_SIX = 5'h0c;
    // reference span per setting, in units of 10 kHz; core clock in same unit
    localparam int CORE_10K = 20000;
    localparam int REF_MIN_10K_HALF = 417;
    localparam int REF_MAX_10K_HALF = 1500;
    localparam int REF_MIN_10K_TWO = 1600;
    localparam int REF_MAX_10K_TWO = 5000;
    localparam int REF_MIN_10K_SIX = 5000;
    localparam int REF_MAX_10K_SIX = 16670;
    // capture range of the tuning in ppm
    localparam int CAPTURE_PPM = 300;
    // flag timing: periods scale with n, plus a fixed pad
    localparam int FAIL_PERIODS = 2;
    localparam int RESTORE_PERIODS = 12;
    localparam int CORE_PERIOD_PS = 5000;
    localparam int FLAG_PAD_NS = 25;
    localparam int FLAG_PAD_CYC = (FLAG_PAD_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
    // validity tracker states
    typedef enum logic [1:0] {
        ST_VALID = 2'b00,
        ST_FAILED = 2'b01,
        ST_RECOVER = 2'b10,
        ST_PAD = 2'b11
    } rcf_state_t;
endpackage
`default_nettype wire

// ### verilog/rcf_mon_if.sv
`timescale 1ns/1ps
`default_nettype none
// carries the reference monitor results to the core
interface rcf_mon_if #(parameter int PW = 16);
    logic refEdge;
    logic fbEdge;
    logic refLevel;
    logic stopped;
    logic [PW-1:0] period;
    logic [PW+4:0] stopLimit;
    modport mon(output refEdge, fbEdge, refLevel, stopped, period, input stopLimit);
    modport core(input refEdge, fbEdge, refLevel, stopped, period, output stopLimit);
endinterface
`default_nettype wire

// ### verilog/rcf_nco.sv
`timescale 1ns/1ps
`default_nettype none
// phase accumulator oscillator, square wave from the accumulator top bit
module rcf_nco #(
    parameter int W = 32
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [W-1:0] word,
    output logic clkOut
);
    logic [W-1:0] acc;

    // accumulate and register the top bit
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            acc <= '0;
            clkOut <= 1'b0;
        end else begin
            acc <= acc + word;
            clkOut <= acc[W-1];
        end
    end
endmodule
`default_nettype wire

// ### verilog/rcf_ref_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// picks the active reference, finds edges, measures period, watches for a stop
module rcf_ref_monitor #(
    parameter int PW = 16
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic refIn1,
    input wire logic refIn2,
    input wire logic referenceChoice,
    input wire logic loopReturnIn,
    rcf_mon_if.mon mon
);
    logic selNow;
    logic fbLevel;
    logic [PW-1:0] sinceEdge;

    // high choice takes the first input, low the second
    assign selNow = referenceChoice ? refIn1 : refIn2; // R1
    assign mon.refEdge = selNow & ~mon.refLevel;
    assign mon.fbEdge = loopReturnIn & ~fbLevel;
    // stop once no edge came for 2n reference periods
    assign mon.stopped = {5'h00, sinceEdge} >= mon.stopLimit; // R12

    // previous levels
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mon.refLevel <= 1'b0;
            fbLevel <= 1'b0;
        end else begin
            mon.refLevel <= selNow;
            fbLevel <= loopReturnIn;
        end
    end

    // period measurement, saturating
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sinceEdge <= '0;
            mon.period <= '0;
        end else if (mon.refEdge) begin
            sinceEdge <= '0;
            mon.period <= sinceEdge + PW'(1);
        end else if (sinceEdge != '1) begin
            sinceEdge <= sinceEdge + PW'(1);
        end
    end

    // skip the first edge after reset, where the level flop still holds its reset value
    a_ref_select: assert property (@(posedge core_clk) disable iff (!rstn) // R1
        $past(rstn) |-> mon.refLevel == $past(selNow))
        else $error("selected reference level does not follow choice");
endmodule
`default_nettype wire

// ### test/rcf_ref_model.sv
`timescale 1ns/1ps
`default_nettype none
// two reference sources sharing one phase, plus the feedback route
module rcf_ref_model (
    input wire logic core_clk,
    input wire logic [1:0] run,
    input wire logic [7:0] half,
    input wire logic fbSrc,
    output logic [1:0] refOut,
    output logic loopReturn
);
    logic [7:0] cnt = 8'h00;
    logic ph = 1'b0;
    // square wave, half period counted in core cycles
    always @(posedge core_clk) begin
        if (cnt + 8'h01 >= half) begin
            cnt <= 8'h00;
            ph <= ~ph;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
    // a stopped source sits low
    assign refOut = run & {2{ph}};
    // one bank output closes the loop
    assign loopReturn = fbSrc;
endmodule
`default_nettype wire

// ### test/tb_rcf_failover_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_rcf_failover_buffer;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic referenceChoice = 1'b1;
    logic [1:0] freqSel = rcf_pkg::FS_TWO;
    logic [1:0] run = 2'b11;
    logic [7:0] half = 8'h02;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [1:0] refOut, bankAClockOut, bankBClockOut;
    logic loopReturnIn, crystalOut, refValid, irq, pready, pslverr;
    logic [31:0] prdata, q;
    logic e, pR, pO, pX;
    int errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int nR = 0;
    int nO = 0;
    int nX = 0;
    int bankDiff = 0;
    int n, a, b, c;
    rcf_failover_buffer #(.TRIM_STEP(4096)) rcf_failover_buffer_i (.core_clk(core_clk), .rstn(rstn),
        .refIn1(refOut[0]), .refIn2(refOut[1]), .referenceChoice(referenceChoice), .freqSel(freqSel),
        .loopReturnIn(loopReturnIn), .crystalOut(crystalOut), .bankAClockOut(bankAClockOut),
        .bankBClockOut(bankBClockOut), .refValid(refValid), .irq(irq), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    rcf_ref_model rcf_ref_model_i (.core_clk(core_clk), .run(run), .half(half),
        .fbSrc(bankAClockOut[0]), .refOut(refOut), .loopReturn(loopReturnIn));
    // clock
    always #2.5 core_clk = ~core_clk;
    // edge counters, bank agreement and hang limit
    always @(posedge core_clk) begin
        pR <= refOut[0];
        pO <= bankAClockOut[0];
        pX <= crystalOut;
        nR <= nR + int'(refOut[0] & ~pR);
        nO <= nO + int'(bankAClockOut[0] & ~pO);
        nX <= nX + int'(crystalOut & ~pX);
        if ({bankAClockOut, bankBClockOut} !== {4{bankAClockOut[0]}}) bankDiff <= bankDiff + 1;
        cyc <= cyc + 1;
        if (cyc == 50000) begin
            errors++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkIn(input int v, input int lo, input int hi);
        total_checks++;
        if (v < lo || v > hi) begin
            errors++;
            $display("CHECK FAILED at %0t: count %0d outside %0d..%0d", $time, v, lo, hi);
        end
    endtask
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // answer taken at the rising edge where pready is sampled high
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so a following setup never reassigns psel in this step
        @(posedge core_clk);
    endtask
    // read and compare the masked bits
    task automatic rdc(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, ad, 32'h0);
        chk(q & m, exp);
    endtask
    // wait until the validity output reaches v, counting cycles
    task automatic waitv(input logic v);
        n = 0;
        @(negedge core_clk);
        while (refValid !== v && n < 20000) begin
            @(negedge core_clk);
            n++;
        end
        @(posedge core_clk);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        chk(refValid, 1'b0);
        rdc(rcf_pkg::ADDR_MASK, 32'h7, 32'h0);
        rdc(rcf_pkg::ADDR_CTRL, 32'h1, 32'h0);
        rdc(8'h10, 32'hffffffff, 32'h0);
        chk(e, 1'b1);
        apb(1'b1, rcf_pkg::ADDR_MASK, 32'h1);
        rdc(rcf_pkg::ADDR_MASK, 32'h7, 32'h1);
        waitv(1'b1);
        chkIn(n, 48, 2000);
        rdc(rcf_pkg::ADDR_STATE, 32'h73, 32'h61);
        rdc(rcf_pkg::ADDR_STATUS, 32'h2, 32'h2);
        a = nR;
        b = nO;
        c = nX;
        repeat (400) @(posedge core_clk);
        chkIn(nO - b, nR - a - 2, nR - a + 2);
        chkIn(nX - c, (nR - a) / 2 - 2, (nR - a) / 2 + 2);
        run <= 2'b10;
        waitv(1'b0);
        chkIn(n, 0, 21);
        chk(irq, 1'b1);
        b = nO;
        repeat (100) @(posedge core_clk);
        chkIn(nO - b, 22, 28);
        rdc(rcf_pkg::ADDR_STATUS, 32'h1, 32'h1);
        rdc(rcf_pkg::ADDR_STATUS, 32'h1, 32'h0);
        @(negedge core_clk);
        chk(irq, 1'b0);
        @(posedge core_clk);
        referenceChoice <= 1'b0;
        waitv(1'b1);
        chkIn(n, 101, 2000);
        half <= 8'h03;
        waitv(1'b0);
        chkIn(n, 1, 19999);
        rdc(rcf_pkg::ADDR_STATUS, 32'h4, 32'h4);
        apb(1'b1, rcf_pkg::ADDR_CTRL, 32'h1);
        rdc(rcf_pkg::ADDR_STATE, 32'h4, 32'h4);
        apb(1'b1, rcf_pkg::ADDR_CTRL, 32'h0);
        half <= 8'h02;
        run <= 2'b11;
        referenceChoice <= 1'b1;
        freqSel <= rcf_pkg::FS_BYPASS;
        repeat (20) @(posedge core_clk);
        rdc(rcf_pkg::ADDR_STATE, 32'h2, 32'h2);
        a = nR;
        b = nO;
        repeat (200) @(posedge core_clk);
        chkIn(nO - b, nR - a - 1, nR - a + 1);
        chk(bankDiff, 32'h0);
        // remaining select codes: ratio six with a 50 MHz reference, then ratio half
        freqSel <= rcf_pkg::FS_SIX;
        repeat (20) @(posedge core_clk);
        rdc(rcf_pkg::ADDR_STATE, 32'h32, 32'h30);
        freqSel <= rcf_pkg::FS_HALF;
        repeat (20) @(posedge core_clk);
        rdc(rcf_pkg::ADDR_STATE, 32'h32, 32'h10);
        test_done();
    end
endmodule
`default_nettype wire
